// File: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import ulms_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clear_send_pin = 1'b1;
  logic [DATA_W-1:0] reg_rdata;
  logic tx_line;
  logic rx_line;
  logic req_send_pin;
  logic modem_irq;
  int error_cnt = 0;
  int comparisons = 0;
  logic [31:0] rv;
  logic [9:0] bits;

  always #20 sys_clk = ~sys_clk;

  ulms_top u_ulms_top (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_line(tx_line), .rx_line(rx_line),
    .req_send_pin(req_send_pin), .clear_send_pin(clear_send_pin), .modem_irq(modem_irq));
  ulms_peer u_ulms_peer (.sys_clk(sys_clk), .tx_line(tx_line), .rx_line(rx_line));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand one cycle only, so they are taken mid-cycle after the strobe edge
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rv = reg_rdata;
    chk(what, e, rv & m);
  endtask
  task automatic settle();
    repeat (5) @(negedge sys_clk);
  endtask

  task automatic t_reset();
    rchk("hs_out", OFS_HS_OUT, '1, RST_HS_OUT);
    rchk("hs_in", OFS_HS_IN, '1, RST_HS_IN);
    rchk("qsts", OFS_QSTS, '1, RST_QSTS);
    rchk("unmapped", 8'h40, '1, 32'h0);
    chk("rts_pin", 1'b0, req_send_pin);
    $display("test reset done");
  endtask
  task automatic t_tx(input logic [31:0] f, input logic [31:0] d, input int n, input logic [9:0] e, input int g);
    wr(OFS_FMT, f);
    wr(OFS_DATA, d);
    wr(OFS_DATA, d);
    rchk("drained_busy", OFS_QSTS, 32'h10000000, 32'h0);
    for (int k = 0; k < 2; k++) begin
      u_ulms_peer.get_char(n, bits);
      chk("tx_bits", {22'h0, e}, {22'h0, bits});
    end
    chk("frame_gap", 1, (u_ulms_peer.gap - g) inside {[-2:2]});
    repeat (BIT_CYC * 2) @(posedge sys_clk);
    rchk("drained", OFS_QSTS, 32'h10000000, 32'h10000000);
    $display("test tx format %h done", f);
  endtask
  task automatic t_line();
    wr(OFS_FMT, 32'h40);
    settle();
    chk("break_line", 1'b0, tx_line);
    wr(OFS_FUNC, 32'h8);
    settle();
    rchk("inactive", OFS_QSTS, 32'h80000000, 32'h0);
    wr(OFS_FMT, 32'h100);
    wr(OFS_FUNC, 32'h0);
    settle();
    chk("inv_line", 1'b0, tx_line);
    wr(OFS_FUNC, {30'h0, FUNC_IRDA});
    settle();
    chk("no_inv_line", 1'b1, tx_line);
    wr(OFS_FUNC, 32'h8);
    wr(OFS_FMT, 32'h0);
    $display("test line done");
  endtask
  task automatic t_rts();
    wr(OFS_HS_OUT, 32'h202);
    settle();
    chk("rts_off_low", 1'b1, req_send_pin);
    rchk("rts_lvl_hi", OFS_HS_OUT, 32'h2000, 32'h2000);
    wr(OFS_HS_OUT, 32'h000);
    settle();
    chk("rts_on_high", 1'b1, req_send_pin);
    wr(OFS_HS_OUT, 32'h002);
    settle();
    rchk("rts_lvl_lo", OFS_HS_OUT, 32'h2000, 32'h0);
    wr(OFS_HS_OUT, 32'h202);
    wr(OFS_IRQ_EN, 32'h1000);
    settle();
    chk("rts_auto", 1'b0, req_send_pin);
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_HS_OUT, 32'h200);
    wr(OFS_FUNC, 32'h1b);
    settle();
    chk("rts_auto_dir", 1'b1, req_send_pin);
    wr(OFS_FUNC, 32'h0);
    $display("test rts done");
  endtask
  task automatic t_cts();
    wr(OFS_IRQ_EN, 32'h8);
    clear_send_pin <= 1'b0;
    settle();
    rchk("cts_change", OFS_HS_IN, 32'h111, 32'h101);
    chk("irq_set", 1'b1, modem_irq);
    wr(OFS_HS_IN, 32'h101);
    settle();
    rchk("cts_clear", OFS_HS_IN, 32'h111, 32'h100);
    chk("irq_clear", 1'b0, modem_irq);
    // Pin change and flag clear land on one edge; the new change must survive
    fork
      wr(OFS_HS_IN, 32'h101);
      begin
        @(posedge sys_clk);
        clear_send_pin <= 1'b1;
      end
    join
    settle();
    rchk("cts_set_wins", OFS_HS_IN, 32'h111, 32'h111);
    chk("irq_kept", 1'b1, modem_irq);
    wr(OFS_HS_IN, 32'h101);
    wr(OFS_IRQ_EN, 32'h0);
    $display("test cts done");
  endtask
  task automatic t_rx();
    wr(OFS_FMT, 32'h1b);
    fork
      u_ulms_peer.send_char(9, 10'h05a);
      begin
        repeat (BIT_CYC * 3) @(posedge sys_clk);
        rchk("rx_busy", OFS_QSTS, 32'h20000000, 32'h0);
      end
    join
    rchk("rx_data", OFS_DATA, '1, 32'h5a);
    rchk("rx_par_ok", OFS_QSTS, 32'h20000010, 32'h20000000);
    u_ulms_peer.send_char(9, 10'h15a);
    rchk("rx_par_err", OFS_QSTS, 32'h10, 32'h10);
    rchk("rx_pop", OFS_DATA, 32'hff, 32'h5a);
    wr(OFS_FMT, 32'h8b);
    u_ulms_peer.send_char(9, 10'h1a5);
    rchk("rx_sw_par", OFS_DATA, '1, 32'h1a5);
    $display("test rx done");
  endtask
  task automatic t_ovf();
    wr(OFS_FUNC, 32'h8);
    settle();
    for (int k = 0; k < 17; k++) begin
      wr(OFS_DATA, 32'h55);
    end
    rchk("tx_full_ovf", OFS_QSTS, 32'h01800000, 32'h01800000);
    wr(OFS_QSTS, 32'h01000000);
    rchk("ovf_clear", OFS_QSTS, 32'h01800000, 32'h00800000);
    $display("test overflow done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_tx(32'h1f, 32'ha7, 9, 10'h1a7, 2604);
    t_tx(32'h04, 32'h15, 5, 10'h015, 1626);
    t_tx(32'h0a, 32'h03, 8, 10'h083, 2170);
    t_tx(32'h39, 32'h3f, 7, 10'h03f, 1953);
    t_tx(32'h29, 32'h00, 7, 10'h040, 1953);
    t_tx(32'h8b, 32'h101, 9, 10'h101, 2387);
    t_line();
    t_rts();
    t_cts();
    t_rx();
    t_ovf();
    print_verdict();
  end
  // Whole run is about 34k cycles; this leaves margin for the slowest frames
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    print_verdict();
  end
endmodule // testbench

// File: dv/ulms_peer.sv
`timescale 1ns/100ps
module ulms_peer (
  input wire logic sys_clk,
  input wire logic tx_line,
  output logic rx_line
);
  import ulms_pkg::*;
  int cyc_cnt = 0;
  int last_start = 0;
  int gap = 0;
  initial rx_line = 1'b1;
  always @(posedge sys_clk) begin
    cyc_cnt <= cyc_cnt + 1;
  end
  // Mid-bit sampling; returns inside the stop bit so a low last bit is not taken for a start
  task automatic get_char(input int n, output logic [9:0] bits);
    int w;
    bits = '0;
    w = 0;
    while (tx_line !== 1'b0 && w < 20000) begin
      @(posedge sys_clk);
      w++;
    end
    // Start-to-start spacing taken at frame starts only; low data bits would look like starts
    gap = cyc_cnt - last_start;
    last_start = cyc_cnt;
    repeat (HALF_CYC) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      bits[i] = tx_line;
    end
    repeat (BIT_CYC) @(posedge sys_clk);
  endtask
  task automatic send_char(input int n, input logic [9:0] bits);
    @(posedge sys_clk);
    rx_line <= 1'b0;
    repeat (BIT_CYC) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      rx_line <= bits[i];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    rx_line <= 1'b1;
    repeat (BIT_CYC) @(posedge sys_clk);
  endtask
endmodule // ulms_peer

// File: rtl/ulms_pkg.sv
package ulms_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN = 8'h04;
  localparam logic [7:0] OFS_FMT = 8'h0c;
  localparam logic [7:0] OFS_HS_OUT = 8'h10;
  localparam logic [7:0] OFS_HS_IN = 8'h14;
  localparam logic [7:0] OFS_QSTS = 8'h18;
  localparam logic [7:0] OFS_FUNC = 8'h30;

  localparam int FMT_LEN = 0;
  localparam int FMT_STOP = 2;
  localparam int FMT_PE = 3;
  localparam int FMT_EVEN = 4;
  localparam int FMT_STICK = 5;
  localparam int FMT_BRK = 6;
  localparam int FMT_PSS = 7;
  localparam int FMT_TXINV = 8;
  localparam int FMT_RXINV = 9;
  localparam int FMT_W = 10;
  localparam logic [9:0] RST_FMT = 10'h000;

  localparam int DAT_PAR = 8;
  localparam int IE_HS = 3;
  localparam int IE_AUTOFLOW = 12;
  localparam int HO_SOFT = 1;
  localparam int HO_POL = 9;
  localparam int HO_LVL = 13;
  localparam int HI_CHG = 0;
  localparam int HI_LVL = 4;
  localparam int HI_POL = 8;
  localparam int QS_ACT = 31;
  localparam int QS_RECEIVER_IDLE = 29;
  localparam int QS_DRAINED = 28;
  localparam int QS_TXOVF = 24;
  localparam int QS_TX_QUEUE_FULL = 23;
  localparam int QS_TXEMPTY = 22;
  localparam int QS_TXPTR = 16;
  localparam int QS_RXFULL = 15;
  localparam int QS_RXEMPTY = 14;
  localparam int QS_RXPTR = 8;
  localparam int QS_PERR = 4;
  localparam int QS_RXOVF = 0;
  localparam int FS_SEL = 0;
  localparam int FS_DIS = 3;
  localparam int FS_AUTODIR = 4;

  localparam logic [31:0] RST_HS_OUT = 32'h00000200;
  localparam logic [31:0] RST_HS_IN = 32'h00000110;
  localparam logic [31:0] RST_QSTS = 32'hb0404000;

  localparam logic [1:0] FUNC_UART = 2'h0;
  localparam logic [1:0] FUNC_LIN = 2'h1;
  localparam logic [1:0] FUNC_IRDA = 2'h2;
  localparam logic [1:0] FUNC_RS485 = 2'h3;

  localparam logic [4:0] QDEPTH = 5'h10;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BAUD_HZ = 115_200;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD_HZ;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam logic [9:0] TMR_ONE = 10'h001;
  localparam logic [9:0] BIT_LOAD = 10'(BIT_CYC - 1);
  localparam logic [9:0] HALF_LOAD = 10'(HALF_CYC - 1);
  localparam logic [9:0] STOP15_LOAD = 10'(3 * HALF_CYC - 1);
  localparam logic [9:0] STOP2_LOAD = 10'(2 * BIT_CYC - 1);

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } ulms_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } ulms_rx_state_t;
endpackage

// File: rtl/ulms_top.sv
// Our own choice: strobed register access.
`timescale 1ns/100ps
module ulms_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [ulms_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ulms_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ulms_pkg::DATA_W-1:0] reg_rdata,
  output logic tx_line,
  input wire logic rx_line,
  output logic req_send_pin,
  input wire logic clear_send_pin,
  output logic modem_irq
);
  import ulms_pkg::*;

  typedef struct packed {
    logic [FMT_W-1:0] fmt;
    logic irq_en_hs;
    logic auto_flow_en;
    logic [1:0] func;
    logic ctl_dis;
    logic auto_dir_en;
    logic rts_soft;
    logic rts_pol;
    logic cts_pol;
    logic cts_lvl;
    logic cts_chg;
    logic tx_ovf;
    logic rx_ovf;
    logic par_err;
    logic [15:0][8:0] txq;
    logic [3:0] tx_wp;
    logic [3:0] tx_rp;
    logic [4:0] tx_cnt;
    logic [15:0][8:0] rxq;
    logic [3:0] rx_wp;
    logic [3:0] rx_rp;
    logic [4:0] rx_cnt;
    ulms_tx_state_t tx_st;
    logic [9:0] tx_tmr;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    ulms_rx_state_t rx_st;
    logic [9:0] rx_tmr;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic tx_line;
    logic rts_pin;
    logic irq;
    logic [31:0] rdata;
  } ulms_state_t;

  ulms_state_t state_ff;
  ulms_state_t nxt_state;
  logic link_act;

  function automatic logic [3:0] char_bits(input logic [1:0] len);
    return {2'h0, len} + 4'h5;
  endfunction

  function automatic logic [7:0] keep_bits(input logic [7:0] d, input logic [1:0] len);
    return d & (8'hff >> (2'h3 - len));
  endfunction

  // Software source passes its bit through, so a receive compare never fails
  function automatic logic par_bit(input logic [7:0] d, input logic [FMT_W-1:0] f, input logic sw);
    if (f[FMT_PSS]) begin
      return sw;
    end
    if (f[FMT_STICK]) begin
      return ~f[FMT_EVEN];
    end
    return f[FMT_EVEN] ? ^d : ~^d;
  endfunction

  // Only idle-with-disable drops the active status
  assign link_act = !(state_ff.ctl_dis && state_ff.tx_st == TX_IDLE && state_ff.rx_st == RX_IDLE);

  always_comb begin
    logic inv_ok;
    logic rx_in;
    logic tx_raw;
    logic tx_tick;
    logic rx_tick;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic req_act;
    logic [9:0] stop_load;
    logic [7:0] rx_word;
    logic [31:0] qsts;
    inv_ok = 1'b0;
    rx_in = 1'b1;
    tx_raw = 1'b1;
    tx_tick = 1'b0;
    rx_tick = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    req_act = 1'b0;
    stop_load = BIT_LOAD;
    rx_word = 8'h00;
    qsts = 32'h00000000;
    nxt_state = state_ff;
    nxt_state.rdata = 32'h00000000;

    inv_ok = state_ff.func != FUNC_IRDA;
    rx_in = rx_line ^ (inv_ok & state_ff.fmt[FMT_RXINV]);
    tx_push = reg_wr && reg_addr == OFS_DATA && state_ff.tx_cnt != QDEPTH;
    rx_pop = reg_rd && reg_addr == OFS_DATA && state_ff.rx_cnt != 5'h00;
    if (state_ff.fmt[FMT_STOP]) begin
      stop_load = (state_ff.fmt[FMT_LEN +: 2] == 2'h0) ? STOP15_LOAD : STOP2_LOAD;
    end

    if (reg_wr) begin
      case (reg_addr)
        OFS_IRQ_EN: begin
          nxt_state.irq_en_hs = reg_wdata[IE_HS];
          nxt_state.auto_flow_en = reg_wdata[IE_AUTOFLOW];
        end
        OFS_FMT: nxt_state.fmt = reg_wdata[FMT_W-1:0];
        OFS_HS_OUT: begin
          nxt_state.rts_soft = reg_wdata[HO_SOFT];
          nxt_state.rts_pol = reg_wdata[HO_POL];
        end
        OFS_HS_IN: begin
          nxt_state.cts_pol = reg_wdata[HI_POL];
          nxt_state.cts_chg = state_ff.cts_chg & ~reg_wdata[HI_CHG];
        end
        OFS_QSTS: begin
          nxt_state.tx_ovf = state_ff.tx_ovf & ~reg_wdata[QS_TXOVF];
          nxt_state.rx_ovf = state_ff.rx_ovf & ~reg_wdata[QS_RXOVF];
          nxt_state.par_err = state_ff.par_err & ~reg_wdata[QS_PERR];
        end
        OFS_FUNC: begin
          nxt_state.func = reg_wdata[FS_SEL +: 2];
          nxt_state.ctl_dis = reg_wdata[FS_DIS];
          nxt_state.auto_dir_en = reg_wdata[FS_AUTODIR];
        end
        default: begin
        end
      endcase
    end
    // Overflow set after the clear so it wins
    if (reg_wr && reg_addr == OFS_DATA && state_ff.tx_cnt == QDEPTH) begin
      nxt_state.tx_ovf = 1'b1;
    end

    // Transmitter
    tx_tick = state_ff.tx_tmr == 10'h000;
    if (!tx_tick) begin
      nxt_state.tx_tmr = state_ff.tx_tmr - TMR_ONE;
    end
    unique case (state_ff.tx_st)
      TX_IDLE: begin
        if (state_ff.tx_cnt != 5'h00 && !state_ff.ctl_dis) begin
          tx_pop = 1'b1;
          nxt_state.tx_sh = keep_bits(state_ff.txq[state_ff.tx_rp][7:0], state_ff.fmt[FMT_LEN +: 2]);
          nxt_state.tx_par = par_bit(nxt_state.tx_sh, state_ff.fmt, state_ff.txq[state_ff.tx_rp][DAT_PAR]);
          nxt_state.tx_st = TX_START;
          nxt_state.tx_tmr = BIT_LOAD;
        end
      end
      TX_START: begin
        tx_raw = 1'b0;
        if (tx_tick) begin
          nxt_state.tx_st = TX_DATA;
          nxt_state.tx_bit = 3'h0;
          nxt_state.tx_tmr = BIT_LOAD;
        end
      end
      TX_DATA: begin
        tx_raw = state_ff.tx_sh[0];
        if (tx_tick) begin
          nxt_state.tx_sh = {1'b0, state_ff.tx_sh[7:1]};
          nxt_state.tx_bit = state_ff.tx_bit + 3'h1;
          nxt_state.tx_tmr = BIT_LOAD;
          if ({1'b0, state_ff.tx_bit} == char_bits(state_ff.fmt[FMT_LEN +: 2]) - 4'h1) begin
            if (state_ff.fmt[FMT_PE]) begin
              nxt_state.tx_st = TX_PAR;
            end else begin
              nxt_state.tx_st = TX_STOP;
              nxt_state.tx_tmr = stop_load;
            end
          end
        end
      end
      TX_PAR: begin
        tx_raw = state_ff.tx_par;
        if (tx_tick) begin
          nxt_state.tx_st = TX_STOP;
          nxt_state.tx_tmr = stop_load;
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          nxt_state.tx_st = TX_IDLE;
        end
      end
      default: nxt_state.tx_st = TX_IDLE;
    endcase
    // Break acts on the pin only, the shifter keeps going
    nxt_state.tx_line = state_ff.fmt[FMT_BRK] ? 1'b0 : tx_raw ^ (inv_ok & state_ff.fmt[FMT_TXINV]);

    // Receiver, sampling at mid-bit; no framing check here
    rx_tick = state_ff.rx_tmr == 10'h000;
    if (!rx_tick) begin
      nxt_state.rx_tmr = state_ff.rx_tmr - TMR_ONE;
    end
    rx_word = {rx_in, state_ff.rx_sh[7:1]};
    unique case (state_ff.rx_st)
      RX_IDLE: begin
        if (!rx_in && !state_ff.ctl_dis) begin
          nxt_state.rx_st = RX_START;
          nxt_state.rx_tmr = HALF_LOAD;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          nxt_state.rx_st = rx_in ? RX_IDLE : RX_DATA;
          nxt_state.rx_bit = 3'h0;
          nxt_state.rx_tmr = BIT_LOAD;
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          nxt_state.rx_sh = rx_word;
          nxt_state.rx_bit = state_ff.rx_bit + 3'h1;
          nxt_state.rx_tmr = BIT_LOAD;
          if ({1'b0, state_ff.rx_bit} == char_bits(state_ff.fmt[FMT_LEN +: 2]) - 4'h1) begin
            nxt_state.rx_sh = rx_word >> (4'h8 - char_bits(state_ff.fmt[FMT_LEN +: 2]));
            nxt_state.rx_st = state_ff.fmt[FMT_PE] ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_tick) begin
          nxt_state.rx_par = rx_in;
          nxt_state.rx_st = RX_STOP;
          nxt_state.rx_tmr = BIT_LOAD;
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          rx_push = 1'b1;
          nxt_state.rx_st = RX_IDLE;
          if (state_ff.fmt[FMT_PE] && state_ff.rx_par != par_bit(state_ff.rx_sh, state_ff.fmt, state_ff.rx_par)) begin
            nxt_state.par_err = 1'b1;
          end
        end
      end
      default: nxt_state.rx_st = RX_IDLE;
    endcase

    // Queues
    if (tx_push) begin
      nxt_state.txq[state_ff.tx_wp] = reg_wdata[8:0];
      nxt_state.tx_wp = state_ff.tx_wp + 4'h1;
    end
    if (tx_pop) begin
      nxt_state.tx_rp = state_ff.tx_rp + 4'h1;
    end
    nxt_state.tx_cnt = state_ff.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
    if (rx_push && state_ff.rx_cnt == QDEPTH) begin
      nxt_state.rx_ovf = 1'b1;
      rx_push = 1'b0;
    end
    if (rx_push) begin
      nxt_state.rxq[state_ff.rx_wp] = {state_ff.fmt[FMT_PE] & state_ff.fmt[FMT_PSS] & state_ff.rx_par,
                                       state_ff.rx_sh};
      nxt_state.rx_wp = state_ff.rx_wp + 4'h1;
    end
    if (rx_pop) begin
      nxt_state.rx_rp = state_ff.rx_rp + 4'h1;
    end
    nxt_state.rx_cnt = state_ff.rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};

    // Handshake lines; pin taken as already synchronous
    nxt_state.cts_lvl = clear_send_pin;
    if (clear_send_pin != state_ff.cts_lvl) begin
      nxt_state.cts_chg = 1'b1;
    end
    nxt_state.irq = nxt_state.cts_chg & nxt_state.irq_en_hs;
    if (state_ff.func == FUNC_UART && state_ff.auto_flow_en) begin
      req_act = state_ff.rx_cnt != QDEPTH;
    end else if (state_ff.func == FUNC_RS485 && state_ff.auto_dir_en) begin
      req_act = state_ff.tx_st != TX_IDLE || state_ff.tx_cnt != 5'h00;
    end else begin
      req_act = !state_ff.rts_soft;
    end
    nxt_state.rts_pin = state_ff.rts_pol ? !req_act : req_act;

    // Read data, one cycle after the strobe
    qsts[QS_ACT] = link_act;
    qsts[QS_RECEIVER_IDLE] = state_ff.rx_st == RX_IDLE;
    qsts[QS_DRAINED] = state_ff.tx_cnt == 5'h00 && state_ff.tx_st == TX_IDLE;
    qsts[QS_TXOVF] = state_ff.tx_ovf;
    qsts[QS_TX_QUEUE_FULL] = state_ff.tx_cnt == QDEPTH;
    qsts[QS_TXEMPTY] = state_ff.tx_cnt == 5'h00;
    qsts[QS_TXPTR +: 6] = {2'h0, state_ff.tx_cnt[3:0]};
    qsts[QS_RXFULL] = state_ff.rx_cnt == QDEPTH;
    qsts[QS_RXEMPTY] = state_ff.rx_cnt == 5'h00;
    qsts[QS_RXPTR +: 6] = {2'h0, state_ff.rx_cnt[3:0]};
    qsts[QS_PERR] = state_ff.par_err;
    qsts[QS_RXOVF] = state_ff.rx_ovf;
    if (reg_rd) begin
      case (reg_addr)
        OFS_DATA: begin
          if (state_ff.rx_cnt != 5'h00) begin
            nxt_state.rdata = {23'h0, state_ff.rxq[state_ff.rx_rp]};
          end
        end
        OFS_IRQ_EN: begin
          nxt_state.rdata[IE_HS] = state_ff.irq_en_hs;
          nxt_state.rdata[IE_AUTOFLOW] = state_ff.auto_flow_en;
        end
        OFS_FMT: nxt_state.rdata[FMT_W-1:0] = state_ff.fmt;
        OFS_HS_OUT: begin
          nxt_state.rdata[HO_SOFT] = state_ff.rts_soft;
          nxt_state.rdata[HO_POL] = state_ff.rts_pol;
          nxt_state.rdata[HO_LVL] = state_ff.rts_pin;
        end
        OFS_HS_IN: begin
          nxt_state.rdata[HI_CHG] = state_ff.cts_chg;
          nxt_state.rdata[HI_LVL] = state_ff.cts_lvl;
          nxt_state.rdata[HI_POL] = state_ff.cts_pol;
        end
        OFS_QSTS: nxt_state.rdata = qsts;
        OFS_FUNC: begin
          nxt_state.rdata[FS_SEL +: 2] = state_ff.func;
          nxt_state.rdata[FS_DIS] = state_ff.ctl_dis;
          nxt_state.rdata[FS_AUTODIR] = state_ff.auto_dir_en;
        end
        default: nxt_state.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= '0;
      state_ff.fmt <= RST_FMT;
      state_ff.rts_pol <= RST_HS_OUT[HO_POL];
      state_ff.cts_pol <= RST_HS_IN[HI_POL];
      state_ff.cts_lvl <= RST_HS_IN[HI_LVL];
      state_ff.tx_line <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;
  assign tx_line = state_ff.tx_line;
  assign req_send_pin = state_ff.rts_pin;
  assign modem_irq = state_ff.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  break_hold_a: assert property (state_ff.fmt[FMT_BRK] |=> !tx_line)
    else $error("break did not hold the line low");
  tx_ovf_set_a: assert property (reg_wr && reg_addr == OFS_DATA && state_ff.tx_cnt == QDEPTH
    |=> state_ff.tx_ovf && state_ff.tx_wp == $past(state_ff.tx_wp))
    else $error("overflow write not flagged or data kept");
  cts_change_a: assert property (clear_send_pin != state_ff.cts_lvl
    |=> state_ff.cts_chg && modem_irq == state_ff.irq_en_hs)
    else $error("clear-to-send change lost");
  queue_bound_a: assert property (state_ff.tx_cnt <= QDEPTH && state_ff.rx_cnt <= QDEPTH)
    else $error("queue count above depth");
  active_hold_a: assert property (!link_act |=> state_ff.tx_st == TX_IDLE && state_ff.rx_st == RX_IDLE)
    else $error("traffic started while inactive");
  drained_read_a: assert property (reg_rd && reg_addr == OFS_QSTS
    |=> reg_rdata[QS_DRAINED] == $past(state_ff.tx_cnt == 5'h00 && state_ff.tx_st == TX_IDLE))
    else $error("drained flag wrong");
  rx_idle_read_a: assert property (reg_rd && reg_addr == OFS_QSTS
    |=> reg_rdata[QS_RECEIVER_IDLE] == $past(state_ff.rx_st == RX_IDLE))
    else $error("receiver idle bit wrong");
  rts_soft_a: assert property (state_ff.func == FUNC_UART && !state_ff.auto_flow_en && !state_ff.rts_soft
    && !state_ff.rts_pol |=> req_send_pin)
    else $error("request pin not active high");
  stop_len_a: assert property (state_ff.tx_st == TX_STOP && $past(state_ff.tx_st) != TX_STOP
    && !state_ff.fmt[FMT_STOP] |-> state_ff.tx_tmr == BIT_LOAD)
    else $error("single stop length wrong");
  start_low_a: assert property (state_ff.tx_st == TX_START && !state_ff.fmt[FMT_BRK]
    && !state_ff.fmt[FMT_TXINV] |=> !tx_line)
    else $error("start bit not low");

  break_c: cover property (state_ff.fmt[FMT_BRK] && state_ff.tx_st == TX_DATA);
  overflow_c: cover property (reg_wr && reg_addr == OFS_DATA && state_ff.tx_cnt == QDEPTH);
  rx_char_c: cover property (state_ff.rx_st == RX_STOP ##1 state_ff.rx_st == RX_IDLE);
  cts_irq_c: cover property ($rose(modem_irq));
endmodule // ulms_top
